/* File: src/swg_regs.svh */
// Purpose: Offsets, field positions, reset values and counts of the sleep, wake and pin block.
// Assumes: Included by bare name from swg_clk_div and swg_top; the package does not include it.
// Notes: Offsets are I/O register addresses on the six-bit register port.
`ifndef SWG_REGS_SVH
`define SWG_REGS_SVH

`define SWG_ADDR_DIR 6'h30
`define SWG_ADDR_OUT 6'h31
`define SWG_ADDR_PIN 6'h32
`define SWG_ADDR_CFG 6'h33
`define SWG_ADDR_BTN 6'h34
`define SWG_ADDR_BAT 6'h35

`define SWG_CFG_SEL_HI 6
`define SWG_CFG_SEL_LO 5
`define SWG_CFG_DIAG 4
`define SWG_CFG_DEAD 3
`define SWG_CFG_LOWM 2
`define SWG_CFG_SLEEP 1
`define SWG_CFG_BOOT 0
`define SWG_DIR_HYST 6
`define SWG_BAT_LOW 7
`define SWG_BAT_VALID 6

`define SWG_RST_DIR 8'h00
`define SWG_RST_OUT 6'h00
`define SWG_RST_SEL 2'h0
`define SWG_RST_FLAGS 6'h00
`define SWG_RST_LEVEL 6'h00

`define SWG_BAT_SAMPLE_CYC 3100
`define SWG_DIV_SPI 7'h0F
`define SWG_DIV_16 7'h0F
`define SWG_DIV_32 7'h1F
`define SWG_DIV_64 7'h3F
`define SWG_DIV_128 7'h7F

`endif

/* File: src/swg_pkg.sv */
// Purpose: Types shared by the sleep, wake and pin block.
// Assumes: Nothing beyond the constant header.
// Notes: Register access requests travel as one packed struct.
package swg_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic we;
    logic re;
    logic [7:0] wdata;
    logic from_spi;
  } swg_io_req_t;

  typedef enum logic [1:0] {
    SWG_RUN,
    SWG_SLEEP,
    SWG_WAKE,
    SWG_BOOT
  } swg_state_t;
endpackage

/* File: src/swg_clk_div.sv */
// Purpose: Derives the processor system clock tick from the crystal clock.
// Assumes: core_clk_i is the crystal clock; a tick is one crystal cycle wide.
// Notes: The select may change at any time; the new limit applies to the count already in progress.
`timescale 1ns/1ps
`default_nettype none
`include "swg_regs.svh"
module swg_clk_div
  import swg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  input wire logic spi_mode_i,
  input wire logic [1:0] sel_i,
  // Tick
  output logic tick_o
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [6:0] limit;

  always_comb
  begin
    case (sel_i)
      2'h3: limit = `SWG_DIV_16;
      2'h2: limit = `SWG_DIV_32;
      2'h1: limit = `SWG_DIV_64;
      default: limit = `SWG_DIV_128;
    endcase
    // Serial programming logic always runs at the fastest rate.
    if (spi_mode_i)
    begin
      limit = `SWG_DIV_SPI;
    end
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run_i)
    begin
      cnt_d = 7'h00;
    end
    else if (cnt_q >= limit)
    begin
      // The compare is >= so a shorter period chosen mid-count wraps at once.
      cnt_d = 7'h00;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule
`default_nettype wire

/* File: src/swg_top.sv */
// Purpose: Pin data, clock divide select, test routing, sleep, button wake and battery check.
// Assumes: core_clk_i is the always-on crystal reference; pins are synchronous to it.
// Notes: Oscillator stop is reported on osc_run_o; this logic itself keeps its clock.
// How it works
// - Outside test mode, output pins drive the output value bits when direction is one.
// - Pin level register reads live pin levels; writes to it do nothing.
// - Divider select 11,10,01,00 gives crystal divided by 16,32,64,128.
// - Divider select may be rewritten at any time by processor or serial port.
// - In serial programming mode the tick runs at crystal divided by 16.
// - Test bit routes key, lock, enable to pins 5..3; pins 2..0 serial when reset low.
// - Serial port pins ignore direction; serial side reaches every register.
// - Battery dead bit reads set only on serial port accesses.
// - Battery low mirror bit always equals the battery low flag.
// - Writing sleep stops oscillator, freezes processor and halts watchdog until wake.
// - Button press in sleep starts oscillator, checks battery, runs or sleeps again.
// - Boot bit plus button wake gives a processor reset; bit clears on exit.
// - Button pin low with good battery sets its press flag.
// - Writing zero to a press flag clears it.
// - With valid set, battery low flag tells battery is below the level field.
// - Threshold write clears valid; valid returns after sampling, up to 3100 cycles.
// - The level field drives the battery monitor comparison level.
// - Direction zero with value one is a button; direction one is an output.
`timescale 1ns/1ps
`default_nettype none
`include "swg_regs.svh"
module swg_top
  import swg_pkg::*;
#(
  parameter int BAT_CYC = `SWG_BAT_SAMPLE_CYC
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire swg_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  // Pins
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe_o,
  input wire logic reset_pin_n_i,
  // Transmitter signals for test routing
  input wire logic tx_key_i,
  input wire logic lock_i,
  input wire logic tx_en_i,
  // Serial programming port
  output logic spi_clk_o,
  output logic spi_sdi_o,
  input wire logic spi_sdo_i,
  output logic spi_mode_o,
  // Battery monitor
  input wire logic bat_low_i,
  input wire logic bat_dead_i,
  output logic [5:0] bat_level_o,
  output logic bat_hyst_o,
  // Core control
  output logic osc_run_o,
  output logic sys_tick_o,
  output logic cpu_freeze_o,
  output logic wdt_run_o,
  output logic core_reset_o
);
  logic [1:0] low_sync_q;
  logic [1:0] dead_sync_q;
  logic bat_low_s;
  logic bat_dead_s;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [5:0] out_q;
  logic [5:0] out_d;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic diag_q;
  logic diag_d;
  logic boot_q;
  logic boot_d;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] level_q;
  logic [5:0] level_d;
  logic valid_q;
  logic valid_d;
  logic blow_q;
  logic blow_d;
  logic [11:0] bcnt_q;
  logic [11:0] bcnt_d;
  swg_state_t st_q;
  swg_state_t st_d;
  logic [11:0] wcnt_q;
  logic [11:0] wcnt_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [5:0] button;
  logic [5:0] press;
  logic [5:0] tst_o;
  logic [5:0] tst_oe;
  logic spi_mode;
  logic sleep_wr;
  logic boot_exit;
  logic div_run;
  logic wr_dir;
  logic wr_out;
  logic wr_cfg;
  logic wr_btn;
  logic wr_bat;

  localparam logic [11:0] BAT_LAST = 12'(BAT_CYC - 1);

  // The first stage is read only by the second.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      low_sync_q <= 2'h0;
      dead_sync_q <= 2'h0;
    end
    else
    begin
      low_sync_q <= {low_sync_q[0], bat_low_i};
      dead_sync_q <= {dead_sync_q[0], bat_dead_i};
    end
  end
  assign bat_low_s = low_sync_q[1];
  assign bat_dead_s = dead_sync_q[1];

  assign spi_mode = diag_q & ~reset_pin_n_i;
  assign button = ~dir_q[5:0] & out_q;
  assign press = button & ~pin_i;
  assign wr_dir = io_req_i.we && io_req_i.addr == `SWG_ADDR_DIR;
  assign wr_out = io_req_i.we && io_req_i.addr == `SWG_ADDR_OUT;
  assign wr_cfg = io_req_i.we && io_req_i.addr == `SWG_ADDR_CFG;
  assign wr_btn = io_req_i.we && io_req_i.addr == `SWG_ADDR_BTN;
  assign wr_bat = io_req_i.we && io_req_i.addr == `SWG_ADDR_BAT;
  assign sleep_wr = wr_cfg && io_req_i.wdata[`SWG_CFG_SLEEP];
  assign boot_exit = st_q == SWG_BOOT;

  // Register file; writes land on either the processor or the serial side.
  always_comb
  begin
    dir_d = dir_q;
    out_d = out_q;
    sel_d = sel_q;
    diag_d = diag_q;
    boot_d = boot_q;
    level_d = level_q;
    valid_d = valid_q;
    blow_d = blow_q;
    bcnt_d = bcnt_q;
    flags_d = flags_q;
    if (wr_dir)
    begin
      dir_d = io_req_i.wdata;
    end
    if (wr_out)
    begin
      out_d = io_req_i.wdata[5:0];
    end
    if (wr_cfg)
    begin
      sel_d = io_req_i.wdata[`SWG_CFG_SEL_HI:`SWG_CFG_SEL_LO];
      diag_d = io_req_i.wdata[`SWG_CFG_DIAG];
      boot_d = io_req_i.wdata[`SWG_CFG_BOOT];
    end
    if (boot_exit)
    begin
      boot_d = 1'b0;
    end
    if (wr_btn)
    begin
      flags_d = flags_q & io_req_i.wdata[5:0];
    end
    // A press in the clearing cycle survives.
    if (!bat_dead_s)
    begin
      flags_d = flags_d | press;
    end
    if (wr_bat)
    begin
      level_d = io_req_i.wdata[5:0];
      valid_d = 1'b0;
      bcnt_d = 12'h000;
    end
    else if (!valid_q)
    begin
      if (bcnt_q >= BAT_LAST)
      begin
        valid_d = 1'b1;
        blow_d = bat_low_s;
      end
      else
      begin
        bcnt_d = bcnt_q + 12'h001;
      end
    end
    else
    begin
      blow_d = bat_low_s;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dir_q <= `SWG_RST_DIR;
      out_q <= `SWG_RST_OUT;
      sel_q <= `SWG_RST_SEL;
      diag_q <= 1'b0;
      boot_q <= 1'b0;
      flags_q <= `SWG_RST_FLAGS;
      level_q <= `SWG_RST_LEVEL;
      valid_q <= 1'b0;
      blow_q <= 1'b0;
      bcnt_q <= 12'h000;
    end
    else
    begin
      dir_q <= dir_d;
      out_q <= out_d;
      sel_q <= sel_d;
      diag_q <= diag_d;
      boot_q <= boot_d;
      flags_q <= flags_d;
      level_q <= level_d;
      valid_q <= valid_d;
      blow_q <= blow_d;
      bcnt_q <= bcnt_d;
    end
  end

  // Sleep and wake sequence. The battery check waits one full sample time,
  // trading wake latency for a settled comparator result.
  always_comb
  begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    case (st_q)
      SWG_RUN:
      begin
        if (sleep_wr)
        begin
          st_d = SWG_SLEEP;
        end
      end
      SWG_SLEEP:
      begin
        wcnt_d = 12'h000;
        if (|press)
        begin
          st_d = SWG_WAKE;
        end
      end
      SWG_WAKE:
      begin
        if (wcnt_q >= BAT_LAST)
        begin
          wcnt_d = 12'h000;
          if (bat_dead_s)
          begin
            st_d = SWG_SLEEP;
          end
          else if (boot_q)
          begin
            st_d = SWG_BOOT;
          end
          else
          begin
            st_d = SWG_RUN;
          end
        end
        else
        begin
          wcnt_d = wcnt_q + 12'h001;
        end
      end
      SWG_BOOT:
      begin
        st_d = SWG_RUN;
      end
      default:
      begin
        st_d = SWG_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= SWG_RUN;
      wcnt_q <= 12'h000;
    end
    else
    begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_comb
  begin
    rdata_d = rdata_q;
    if (io_req_i.re)
    begin
      case (io_req_i.addr)
        `SWG_ADDR_DIR: rdata_d = dir_q;
        `SWG_ADDR_OUT: rdata_d = {2'h0, out_q};
        `SWG_ADDR_PIN: rdata_d = {2'h0, pin_i};
        `SWG_ADDR_CFG: rdata_d = {1'b0, sel_q, diag_q,
                                  io_req_i.from_spi & bat_dead_s,
                                  blow_q, 1'b0, boot_q};
        `SWG_ADDR_BTN: rdata_d = {2'h0, flags_q};
        `SWG_ADDR_BAT: rdata_d = {blow_q, valid_q, level_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Test routing: transmitter signals follow direction, serial pins do not.
  always_comb
  begin
    tst_o = {tx_key_i, lock_i, tx_en_i, 3'h0};
    tst_oe = {dir_q[5:3], 3'h0};
    if (!reset_pin_n_i)
    begin
      tst_o[1] = spi_sdo_i;
      tst_oe[1] = 1'b1;
    end
  end

  for (genvar i = 0; i < 6; i++)
  begin : g_pin
    assign pin_o[i] = diag_q ? tst_o[i] : out_q[i];
    assign pin_oe_o[i] = diag_q ? tst_oe[i] : dir_q[i];
  end

  assign spi_clk_o = spi_mode & pin_i[2];
  assign spi_sdi_o = spi_mode & pin_i[0];
  assign spi_mode_o = spi_mode;

  assign div_run = st_q == SWG_RUN || spi_mode;

  swg_clk_div u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .run_i(div_run),
    .spi_mode_i(spi_mode),
    .sel_i(sel_q),
    .tick_o(sys_tick_o)
  );

  assign osc_run_o = st_q != SWG_SLEEP;
  assign cpu_freeze_o = st_q != SWG_RUN;
  assign wdt_run_o = st_q == SWG_RUN;
  assign core_reset_o = st_q == SWG_BOOT;
  assign bat_level_o = level_q;
  assign bat_hyst_o = dir_q[`SWG_DIR_HYST];
  assign io_rdata_o = rdata_q;
endmodule
`default_nettype wire

/* File: tb/swg_top_monitor.sv */
// Purpose: Port-level checks of the sleep, wake and pin block.
// Assumes: Bound to swg_top; one clock domain.
// Notes: Wake length scales with BAT_CYC, so a counter bounds it.
`timescale 1ns/1ps
`default_nettype none
module swg_top_monitor
  import swg_pkg::*;
#(
  parameter int BAT_CYC = 3100
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire swg_io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic [5:0] pin_i,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe_o,
  input wire logic spi_clk_o,
  input wire logic spi_sdi_o,
  input wire logic spi_sdo_i,
  input wire logic spi_mode_o,
  input wire logic [5:0] bat_level_o,
  input wire logic osc_run_o,
  input wire logic sys_tick_o,
  input wire logic cpu_freeze_o,
  input wire logic wdt_run_o,
  input wire logic core_reset_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [15:0] wake_q;
  logic [15:0] wake_d;
  always_comb wake_d = (osc_run_o && cpu_freeze_o) ? wake_q + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i) wake_q <= 16'h0000;
    else wake_q <= wake_d;
  sequence s_thr_wr;
    io_req_i.we && io_req_i.addr == 6'h35;
  endsequence
  sequence s_thr_rd;
    io_req_i.re && io_req_i.addr == 6'h35;
  endsequence
  a_valid_clear: assert property (s_thr_wr ##1 s_thr_rd |=> !io_rdata_o[6])
    else $error("valid bit seen after threshold write");
  a_level_fwd: assert property (s_thr_wr |=> bat_level_o == $past(io_req_i.wdata[5:0]))
    else $error("level field not forwarded");
  a_pin_read: assert property (io_req_i.re && io_req_i.addr == 6'h32 |=>
    io_rdata_o == {2'h0, $past(pin_i)}) else $error("pin read differs");
  a_dead_hidden: assert property (io_req_i.re && io_req_i.addr == 6'h33
    && !io_req_i.from_spi |=> !io_rdata_o[3]) else $error("dead bit seen by processor");
  a_sleep_entry: assert property (io_req_i.we && io_req_i.addr == 6'h33
    && io_req_i.wdata[1] && wdt_run_o |=> !osc_run_o && cpu_freeze_o && !wdt_run_o)
    else $error("sleep not entered");
  a_tick_stop: assert property ((cpu_freeze_o && !spi_mode_o)[*2] |-> !sys_tick_o)
    else $error("tick while frozen");
  a_wake_bound: assert property (wake_q <= BAT_CYC + 2)
    else $error("wake check too long");
  a_boot_pulse: assert property (core_reset_o |=> !core_reset_o && !cpu_freeze_o)
    else $error("boot pulse wrong");
  a_spi_route: assert property (spi_mode_o |-> spi_clk_o == pin_i[2]
    && spi_sdi_o == pin_i[0] && pin_oe_o[1] && pin_o[1] == spi_sdo_i)
    else $error("serial pins not routed");
endmodule
`default_nettype wire

/* File: tb/swg_board_model.sv */
// Purpose: Buttons, pull-ups and battery monitor around the block.
// Assumes: Every pin has a board pull-up; a pressed button grounds it.
// Notes: Comparator outputs move off the crystal edges on purpose.
`timescale 1ns/1ps
`default_nettype none
module swg_board_model (
  // Pins
  input wire logic [5:0] drv_i,
  input wire logic [5:0] drv_oe_i,
  input wire logic [5:0] press_i,
  output logic [5:0] level_o,
  // Battery monitor
  input wire logic low_i,
  input wire logic dead_i,
  output logic bat_low_o,
  output logic bat_dead_o
);
  always_comb
    for (int k = 0; k < 6; k++)
      level_o[k] = drv_oe_i[k] ? drv_i[k] : !press_i[k];
  // Delayed so the block cannot rely on edge-aligned levels.
  assign #3 bat_low_o = low_i;
  assign #3 bat_dead_o = dead_i;
endmodule
`default_nettype wire

/* File: tb/swg_top_tb.sv */
// Purpose: Self-checking bench for the sleep, wake and pin block.
// Assumes: Inputs change at the falling edge; BAT_CYC shortened to 8.
// Notes: A lingering strobe would repeat an access, so runs end in idle.
`timescale 1ns/1ps
`default_nettype none
module swg_top_tb
  import swg_pkg::*;
();
  localparam int BC = 8;
  logic core_clk_i, rst_b_i, rpin_n, tx_key, lock, tx_en, sdo, low, dead, bat_low, bat_dead;
  logic sclk, ssdi, smode, hyst, osc, tick, frz, wdt, crst;
  logic [5:0] pin_lvl, pin_drv, pin_oe, press, lvl_fld;
  logic [7:0] rdata;
  swg_io_req_t req;
  int err_count, total_checks, n;
  logic [5:0] ta [5] = '{6'h30, 6'h31, 6'h32, 6'h34, 6'h36};
  logic [7:0] te [5] = '{8'hFF, 8'h3F, 8'h3F, 8'h00, 8'h00};
  swg_top #(.BAT_CYC(BC)) i_swg_top (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .io_req_i(req), .io_rdata_o(rdata),
    .pin_i(pin_lvl), .pin_o(pin_drv), .pin_oe_o(pin_oe), .reset_pin_n_i(rpin_n),
    .tx_key_i(tx_key), .lock_i(lock), .tx_en_i(tx_en), .spi_clk_o(sclk),
    .spi_sdi_o(ssdi), .spi_sdo_i(sdo), .spi_mode_o(smode), .bat_low_i(bat_low),
    .bat_dead_i(bat_dead), .bat_level_o(lvl_fld), .bat_hyst_o(hyst), .osc_run_o(osc),
    .sys_tick_o(tick), .cpu_freeze_o(frz), .wdt_run_o(wdt), .core_reset_o(crst));
  swg_board_model i_swg_board_model (.drv_i(pin_drv), .drv_oe_i(pin_oe), .press_i(press),
    .level_o(pin_lvl), .low_i(low), .dead_i(dead), .bat_low_o(bat_low), .bat_dead_o(bat_dead));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d, input logic s);
    req = '{addr: a, we: w, re: !w, wdata: d, from_spi: s};
    @(negedge core_clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic s = 1'b0);
    op(1'b0, a, 8'h00, s);
    check("read", rdata, e);
  endtask
  task automatic cyc(input int k);
    req = '0;
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    for (n = 0; n < 2000 && s !== v; n++) @(negedge core_clk_i);
    if (s !== v)
    begin
      check("wait", 8'h00, 8'h01);
      results();
    end
  endtask
  task automatic period(input logic [7:0] e);
    wait_for(tick, 1'b1);
    n = 0;
    do
    begin
      @(negedge core_clk_i);
      n++;
    end while (tick !== 1'b1 && n < 300);
    // A tick that never returns is a hang, so it ends the run like any other wait.
    if (tick !== 1'b1)
    begin
      check("wait", 8'h00, 8'h01);
      results();
    end
    check("period", n[7:0], e);
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = !core_clk_i;
  end
  initial
  begin
    {rst_b_i, low, dead, sdo, lock} = '0;
    {rpin_n, tx_key, tx_en} = '1;
    press = '0;
    req = '0;
    repeat (12) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    rd(6'h35, 8'h00);
    rd(6'h30, 8'h00);
    rd(6'h33, 8'h00);
    rd(6'h34, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      op(1'b1, ta[i], 8'hFF, 1'b0);
      rd(ta[i], te[i]);
    end
    check("hyst", hyst, 8'h01);
    op(1'b1, 6'h31, 8'h2A, 1'b0);
    cyc(1);
    check("drive", pin_drv, 8'h2A);
    check("oe", pin_oe, 8'h3F);
    op(1'b1, 6'h30, 8'h00, 1'b0);
    press = 6'h05;
    rd(6'h32, 8'h3A);
    press = 6'h00;
    for (int s = 3; s >= 0; s--)
    begin
      op(1'b1, 6'h33, 8'(s << 5), 1'b0);
      cyc(0);
      period(8'(128 >> s));
    end
    op(1'b1, 6'h35, 8'h15, 1'b0);
    rd(6'h35, 8'h15);
    check("level", lvl_fld, 8'h15);
    low = 1'b1;
    cyc(BC + 6);
    rd(6'h35, 8'hD5);
    rd(6'h33, 8'h04);
    dead = 1'b1;
    cyc(4);
    rd(6'h33, 8'h0C, 1'b1);
    rd(6'h33, 8'h04);
    op(1'b1, 6'h31, 8'h01, 1'b0);
    press = 6'h01;
    rd(6'h34, 8'h00);
    dead = 1'b0;
    cyc(4);
    rd(6'h34, 8'h01);
    press = 6'h00;
    op(1'b1, 6'h34, 8'h3E, 1'b0);
    rd(6'h34, 8'h00);
    // Pin 0 stays a button, so the part can be woken.
    dead = 1'b1;
    cyc(3);
    op(1'b1, 6'h33, 8'h02, 1'b0);
    cyc(3);
    check("sleep", {osc, frz, wdt}, 8'h02);
    press = 6'h01;
    wait_for(osc, 1'b1);
    press = 6'h00;
    wait_for(osc, 1'b0);
    check("resleep", frz, 8'h01);
    dead = 1'b0;
    cyc(3);
    press = 6'h01;
    wait_for(osc, 1'b1);
    press = 6'h00;
    wait_for(frz, 1'b0);
    op(1'b1, 6'h33, 8'h03, 1'b0);
    cyc(2);
    press = 6'h01;
    wait_for(crst, 1'b1);
    press = 6'h00;
    // The boot bit only clears as the reset state is left, at the edge that ends the one-cycle pulse.
    cyc(1);
    check("boot end", {crst, frz}, 8'h00);
    rd(6'h33, 8'h04);
    op(1'b1, 6'h30, 8'h38, 1'b0);
    op(1'b1, 6'h33, 8'h10, 1'b0);
    cyc(1);
    check("test oe", pin_oe, 8'h38);
    check("test out", pin_drv & 6'h38, 8'h28);
    rpin_n = 1'b0;
    sdo = 1'b1;
    press = 6'h05;
    cyc(2);
    check("serial", {smode, pin_oe[1], pin_drv[1], sclk, ssdi}, 8'h1C);
    period(8'h10);
    op(1'b1, 6'h33, 8'h70, 1'b1);
    rd(6'h33, 8'h74, 1'b1);
    cyc(2);
    results();
  end
endmodule
bind swg_top swg_top_monitor #(.BAT_CYC(BAT_CYC)) i_swg_top_monitor (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .io_req_i(io_req_i), .io_rdata_o(io_rdata_o),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .spi_clk_o(spi_clk_o),
  .spi_sdi_o(spi_sdi_o), .spi_sdo_i(spi_sdo_i), .spi_mode_o(spi_mode_o),
  .bat_level_o(bat_level_o), .osc_run_o(osc_run_o), .sys_tick_o(sys_tick_o),
  .cpu_freeze_o(cpu_freeze_o), .wdt_run_o(wdt_run_o), .core_reset_o(core_reset_o));
`default_nettype wire
